// ==== curve_memory_const_units.sv ====
// Curve converter, retained value block and constant bank with an APB
// register port and a handshake to the nonvolatile store.
// Assumes an APB master, and a store that answers a read request once.
// How it works
// - The curve is eight x/y pairs held in the parameter table.
// - Inputs at or below x1 give y1, at or beyond x8 give y8.
// - Between, the result is the line through the bracketing pairs.
// - The curve takes a 16-bit input and gives a 32-bit result.
// - The curve is evaluated in one of four configurable steps.
// - With enable zero or negative the last retained result is sent to the store.
// - After reset the retained result is loaded from the store.
// - The retained block takes 16-bit value and enable, gives 32 bits.
// - Twenty signed 31-bit constants are driven as 32-bit words.
// - The curve and retained units are evaluated once per 20 ms control cycle; constants follow each write.
`timescale 1ns/10ps
module curve_memory_const_units
#(
  parameter int CYCLE_CLKS = curve_memory_const_pkg::CYCLE_CLKS
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] curve_input,
  output logic [31:0] curve_result,
  input wire logic [15:0] retain_value,
  input wire logic [15:0] retain_enable,
  output logic [31:0] retained_result,
  output logic [32*curve_memory_const_pkg::NUM_CONSTS-1:0] constant_word,
  output logic nv_rd_req,
  input wire logic nv_rd_valid,
  input wire logic [31:0] nv_rd_data,
  output logic nv_wr,
  output logic [31:0] nv_wr_data
);
  typedef struct packed
  {
    curve_memory_const_pkg::seq_e st;
    logic [31:0] tick_cnt;
    logic [1:0] step;
    logic [1:0] cfg_step;
    logic [15:0] act_delay;
    logic [15:0] delay_cnt;
    logic [31:0] curve;
    logic [31:0] retain;
    logic nv_rd_req;
    logic nv_wr;
    logic [31:0] nv_wdata;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

  localparam int DEPTH = curve_memory_const_pkg::TABLE_DEPTH;
  localparam int NP = curve_memory_const_pkg::NUM_POINTS;

  state_s q;
  state_s d;
  logic [31:0] tbl_rdata;
  logic [DEPTH*32-1:0] tbl_all;
  logic tbl_we;
  logic [31:0] tbl_wdata;
  logic [5:0] tbl_idx;
  logic in_table;
  logic [31:0] curve_calc;

  assign tbl_idx = paddr[7:2];
  assign in_table = (paddr < curve_memory_const_pkg::TABLE_END);
  assign tbl_we = psel && penable && q.pready && pwrite && in_table;
  // Constants are sign-extended from bit 30
  assign tbl_wdata = (tbl_idx >= curve_memory_const_pkg::CONST_INDEX) ?
    {pwdata[30], pwdata[30:0]} : pwdata;

  param_table #(.WIDTH(32), .DEPTH(DEPTH), .AW(6)) u_table
  (
    .mclk(mclk),
    .rst(rst),
    .we(tbl_we),
    .waddr(tbl_idx),
    .wdata(tbl_wdata),
    .raddr(tbl_idx),
    .rdata(tbl_rdata),
    .all_words(tbl_all)
  );

  // Curve lookup and interpolation
  always_comb
  begin
    logic signed [15:0] xin;
    logic signed [15:0] xa;
    logic signed [15:0] xb;
    logic signed [31:0] ya;
    logic signed [31:0] yb;
    logic signed [16:0] dx;
    logic signed [16:0] span;
    logic signed [32:0] dy;
    logic signed [49:0] prod;
    logic signed [49:0] quot;
    logic [2:0] seg;
    xin = signed'(curve_input);
    seg = 3'h0;
    for (int i = 1; i < NP - 1; i++)
    begin
      if (xin >= signed'(tbl_all[i*32 +: 16]))
      begin
        seg = 3'(i);
      end
    end
    xa = signed'(tbl_all[seg*32 +: 16]);
    xb = signed'(tbl_all[(seg+1)*32 +: 16]);
    ya = signed'(tbl_all[(seg+NP)*32 +: 32]);
    yb = signed'(tbl_all[(seg+NP+1)*32 +: 32]);
    dx = 17'(xin) - 17'(xa);
    span = 17'(xb) - 17'(xa);
    dy = 33'(yb) - 33'(ya);
    prod = 50'(dx) * 50'(dy);
    quot = (span == 17'sh0) ? 50'sh0 : prod / 50'(span);
    if (xin <= signed'(tbl_all[15:0]))
    begin
      curve_calc = tbl_all[NP*32 +: 32];
    end
    else if (xin >= signed'(tbl_all[(NP-1)*32 +: 16]))
    begin
      curve_calc = tbl_all[(2*NP-1)*32 +: 32];
    end
    else
    begin
      curve_calc = 32'(ya + quot[31:0]);
    end
  end

  always_comb
  begin
    logic tick;
    tick = (q.tick_cnt == 32'(CYCLE_CLKS - 1));
    d = q;
    d.nv_wr = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.tick_cnt = tick ? 32'h00000000 : q.tick_cnt + 32'h00000001;
    case (q.st)
      curve_memory_const_pkg::ST_LOAD:
      begin
        if (nv_rd_valid)
        begin
          d.retain = nv_rd_data;
          d.nv_rd_req = 1'b0;
          d.st = curve_memory_const_pkg::ST_IDLE;
        end
      end
      curve_memory_const_pkg::ST_IDLE:
      begin
        if (tick)
        begin
          d.step = 2'h0;
          d.st = curve_memory_const_pkg::ST_EVAL;
        end
      end
      curve_memory_const_pkg::ST_EVAL:
      begin
        if (q.step == q.cfg_step)
        begin
          d.curve = curve_calc;
        end
        if (q.step == 2'h0)
        begin
          if (signed'(retain_enable) > 16'sh0000)
          begin
            if (q.delay_cnt >= q.act_delay)
            begin
              d.retain = 32'(signed'(retain_value));
            end
            else
            begin
              d.delay_cnt = q.delay_cnt + 16'h0001;
            end
          end
          else
          begin
            d.delay_cnt = 16'h0000;
            d.nv_wr = 1'b1;
            d.nv_wdata = q.retain;
          end
        end
        d.step = q.step + 2'h1;
        if (q.step == 2'(curve_memory_const_pkg::NUM_STEPS - 1))
        begin
          d.st = curve_memory_const_pkg::ST_IDLE;
        end
      end
      default:
      begin
        d.st = curve_memory_const_pkg::ST_IDLE;
      end
    endcase
    // APB: one wait cycle, answer registered
    if (psel && penable && !q.pready)
    begin
      d.pready = 1'b1;
      d.prdata = 32'h00000000;
      if (paddr[11:8] != 4'h0)
      begin
        d.pslverr = 1'b1;
      end
      else if (in_table)
      begin
        d.prdata = pwrite ? 32'h00000000 : tbl_rdata;
      end
      else
      begin
        case ({paddr[7:2], 2'b00})
          curve_memory_const_pkg::CTRL_ADDR[7:0]:
            d.prdata = pwrite ? 32'h00000000 : 32'(q.cfg_step);
          curve_memory_const_pkg::DELAY_ADDR[7:0]:
            d.prdata = pwrite ? 32'h00000000 : 32'(q.act_delay);
          curve_memory_const_pkg::CURVE_ADDR[7:0]:
          begin
            d.prdata = q.curve;
            d.pslverr = pwrite;
          end
          curve_memory_const_pkg::RETAIN_ADDR[7:0]:
          begin
            d.prdata = q.retain;
            d.pslverr = pwrite;
          end
          curve_memory_const_pkg::STATUS_ADDR[7:0]:
          begin
            d.prdata = {24'h000000, q.delay_cnt[2:0], q.st, q.step};
            d.pslverr = pwrite;
          end
          default:
            d.pslverr = 1'b1;
        endcase
      end
    end
    if (psel && penable && q.pready && pwrite && (paddr[11:8] == 4'h0))
    begin
      if ({paddr[7:2], 2'b00} == curve_memory_const_pkg::CTRL_ADDR[7:0])
      begin
        d.cfg_step = pwdata[curve_memory_const_pkg::CTRL_STEP_LSB +: 2];
      end
      if ({paddr[7:2], 2'b00} == curve_memory_const_pkg::DELAY_ADDR[7:0])
      begin
        d.act_delay = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= curve_memory_const_pkg::ST_LOAD;
      q.nv_rd_req <= 1'b1;
      q.cfg_step <= curve_memory_const_pkg::CTRL_STEP_RST;
      q.act_delay <= curve_memory_const_pkg::DELAY_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign curve_result = q.curve;
  assign retained_result = q.retain;
  assign constant_word = tbl_all[DEPTH*32-1 : 2*NP*32];
  assign nv_rd_req = q.nv_rd_req;
  assign nv_wr = q.nv_wr;
  assign nv_wr_data = q.nv_wdata;
endmodule

// ==== curve_memory_const_pkg.sv ====
// Constants, register map and types of the curve, retained value and
// constant units.
// Assumes a 200 MHz clock and an APB master with 32-bit data.
package curve_memory_const_pkg;
  // Table sizes and step count
  localparam int NUM_POINTS = 8;
  localparam int NUM_CONSTS = 20;
  localparam int TABLE_DEPTH = 2 * NUM_POINTS + NUM_CONSTS;
  localparam int NUM_STEPS = 4;
  // Byte addresses
  localparam logic [11:0] X_BASE = 12'h000;
  localparam logic [11:0] Y_BASE = 12'h020;
  localparam logic [11:0] CONST_BASE = 12'h040;
  localparam logic [11:0] TABLE_END = 12'h090;
  localparam logic [11:0] CTRL_ADDR = 12'h090;
  localparam logic [11:0] DELAY_ADDR = 12'h094;
  localparam logic [11:0] CURVE_ADDR = 12'h098;
  localparam logic [11:0] RETAIN_ADDR = 12'h09c;
  localparam logic [11:0] STATUS_ADDR = 12'h0a0;
  // Table entry indices
  localparam logic [5:0] Y_INDEX = 6'h08;
  localparam logic [5:0] CONST_INDEX = 6'h10;
  // Field positions and reset values
  localparam int CTRL_STEP_LSB = 0;
  localparam int STATUS_STATE_LSB = 2;
  localparam logic [1:0] CTRL_STEP_RST = 2'h0;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [31:0] TABLE_RST = 32'h00000000;
  // Control cycle timing
  localparam int CTRL_PERIOD_MS = 20;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int CYCLE_CLKS = CTRL_PERIOD_MS * CLK_FREQ_KHZ;
  // Sequencer states
  typedef enum logic [2:0]
  {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_EVAL = 3'b100
  } seq_e;
endpackage

// ==== param_table.sv ====
// Parameter table: curve points and constants, one write port, one
// registered read port and a parallel view of every entry.
// Assumes a single writer and the clock mclk.
`timescale 1ns/10ps
module param_table
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = curve_memory_const_pkg::TABLE_DEPTH,
  parameter int AW = 6
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata,
  output logic [DEPTH*WIDTH-1:0] all_words
);
  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata;
  } table_s;

  table_s q;
  table_s d;

  always_comb
  begin
    d = q;
    if (we && (int'(waddr) < DEPTH))
    begin
      d.mem[waddr] = wdata;
    end
    if (int'(raddr) < DEPTH)
    begin
      d.rdata = q.mem[raddr];
    end
    else
    begin
      d.rdata = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign all_words = q.mem;
endmodule

// ==== curve_memory_const_units_sva.sv ====
// Checker for the retained value block and its store handshake.
// Assumes binding into curve_memory_const_units; sees ports only.
`timescale 1ns/10ps
module cmc_units_sva
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic nv_rd_req,
  input wire logic nv_rd_valid,
  input wire logic [31:0] nv_rd_data,
  input wire logic nv_wr,
  input wire logic [31:0] nv_wr_data,
  input wire logic [31:0] retained_result,
  input wire logic [15:0] retain_value,
  input wire logic [15:0] retain_enable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_wr_when_off: assert property (
    nv_wr |-> $signed($past(retain_enable)) <= 0)
    else $error("store write while enabled");
  a_wr_last_value: assert property (
    nv_wr |-> nv_wr_data == retained_result)
    else $error("store write data differs");
  a_wr_once_cycle: assert property (
    nv_wr |=> !nv_wr [*8])
    else $error("store writes too close");
  a_load_value: assert property (
    nv_rd_req && nv_rd_valid |=>
    !nv_rd_req && retained_result == $past(nv_rd_data))
    else $error("restored value wrong");
  a_load_wait: assert property (
    nv_rd_req && !nv_rd_valid |=> nv_rd_req)
    else $error("store request dropped early");
  a_load_once: assert property (
    !nv_rd_req |=> !nv_rd_req)
    else $error("store request raised again");
  a_take_value: assert property (
    $changed(retained_result) && !$past(nv_rd_req) |->
    $signed(retained_result) == $signed($past(retain_value)))
    else $error("retained result not the input");
  a_hold_off: assert property (
    ($signed(retain_enable) <= 0 && !nv_rd_req) [*2] |=>
    $stable(retained_result))
    else $error("retained result moved while off");
endmodule
bind curve_memory_const_units cmc_units_sva i_sva
(
  .mclk, .rst, .nv_rd_req, .nv_rd_valid, .nv_rd_data, .nv_wr,
  .nv_wr_data, .retained_result, .retain_value, .retain_enable
);

// ==== tb_curve_memory_const_units.sv ====
// Testbench for the curve, retained value and constant units.
// Drives APB and the store handshake itself; short control cycle.
`timescale 1ns/10ps
module tb_curve_memory_const_units;
  localparam int CYC = 20;
  localparam logic [15:0] CIN [9] = '{16'd50, 16'd100, 16'd103,
    16'd250, 16'd799, 16'd800, 16'h7fff, 16'h8000, 16'd450};
  localparam int CEX [9] = '{0, 0, 0, -25, -488, -490, -490, 0, -125};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] curve_input = 16'h0, retain_value = 16'h0;
  logic [15:0] retain_enable = 16'h0;
  logic nv_rd_valid = 1'b0;
  logic [31:0] nv_rd_data = 32'h0;
  logic pready, pslverr, nv_rd_req, nv_wr;
  logic [31:0] prdata, curve_result, retained_result, nv_wr_data;
  logic [32*curve_memory_const_pkg::NUM_CONSTS-1:0] constant_word;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int checks_done = 0;
  int cyc_count = 0;
  curve_memory_const_units #(.CYCLE_CLKS(CYC)) i_dut
  (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .curve_input, .curve_result, .retain_value,
    .retain_enable, .retained_result, .constant_word, .nv_rd_req,
    .nv_rd_valid, .nv_rd_data, .nv_wr, .nv_wr_data
  );
  always #2.5 mclk = ~mclk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc_count++;
    if (cyc_count == 5000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_wr(input logic [31:0] e);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (nv_wr !== 1'b1 && n < 3 * CYC);
    chk({31'h0, nv_wr}, 32'h1);
    chk(nv_wr_data, e);
  endtask
  task automatic t_load(input logic [31:0] d);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    wt(3);
    chk({31'h0, nv_rd_req}, 32'h1);
    nv_rd_valid <= 1'b1;
    nv_rd_data <= d;
    wt(1);
    nv_rd_valid <= 1'b0;
    nv_rd_data <= ~d;
    wt(2);
    chk(retained_result, d);
    chk({31'h0, nv_rd_req}, 32'h0);
    apb(1'b0, 12'h0a0, 32'h0);
    chk(rd, 32'h00000008);
    $display("load test done");
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h090, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h094, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0a4, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h098, 32'h5);
    chk({31'h0, err}, 32'h1);
    $display("register test done");
  endtask
  task automatic t_consts;
    for (int k = 0; k < 20; k++)
      apb(1'b1, 12'h040 + 12'(4 * k), {1'b1, k[0], 30'(k)});
    for (int k = 0; k < 20; k++)
    begin
      apb(1'b0, 12'h040 + 12'(4 * k), 32'h0);
      chk(rd, {k[0], k[0], 30'(k)});
      chk(constant_word[32 * k +: 32], {k[0], k[0], 30'(k)});
    end
    $display("constant test done");
  endtask
  task automatic t_curve;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 12'(4 * i), 32'(100 * (i + 1)));
      apb(1'b1, 12'h020 + 12'(4 * i), 32'(-10 * i * i));
    end
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, 12'h090, 32'(i % 4));
      apb(1'b0, 12'h090, 32'h0);
      chk(rd, 32'(i % 4));
      curve_input <= CIN[i];
      wt(2 * CYC + 10);
      chk(curve_result, 32'(CEX[i]));
      apb(1'b0, 12'h098, 32'h0);
      chk(rd, 32'(CEX[i]));
    end
    // Step 3: input changed after step 0 must still be taken
    apb(1'b1, 12'h090, 32'h3);
    wait_wr(32'h1234abcd);
    curve_input <= CIN[3];
    wt(1);
    chk(curve_result, 32'(CEX[8]));
    wt(2);
    chk(curve_result, 32'(CEX[3]));
    $display("curve test done");
  endtask
  task automatic t_retain(input logic [31:0] r0);
    apb(1'b1, 12'h094, 32'h2);
    retain_value <= 16'hfffb;
    wait_wr(r0);
    retain_enable <= 16'h0001;
    wt(50);
    chk(retained_result, r0);
    wt(20);
    chk(retained_result, 32'hfffffffb);
    retain_enable <= 16'hffff;
    wait_wr(32'hfffffffb);
    retain_value <= 16'h0007;
    retain_enable <= 16'h0001;
    wt(50);
    chk(retained_result, 32'hfffffffb);
    wt(20);
    chk(retained_result, 32'h00000007);
    apb(1'b0, 12'h09c, 32'h0);
    chk(rd, 32'h00000007);
    $display("retain test done");
  endtask
  initial
  begin
    t_load(32'h1234abcd);
    t_regs();
    t_consts();
    t_curve();
    t_retain(32'h1234abcd);
    t_load(32'h00000055);
    wrap_up();
  end
endmodule
